//--- logic/cpf_consts.svh
/*
 * Register offsets, field positions and reset values for the
 * character processing and flow status block.
 * Assumes inclusion by bare name from design files of this block.
 */
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define CPF_IDX_STATUS    8'h0b
`define CPF_IDX_COUNT     8'h0e
`define CPF_IDX_SCH1      8'h1a
`define CPF_IDX_SCH2      8'h1b
`define CPF_IDX_SCH3      8'h1c
`define CPF_IDX_SCH4      8'h1d
`define CPF_IDX_OPT5      8'h1f
`define CPF_IDX_LIT_NEXT  8'h24
`define CPF_IDX_CMD       8'h05
`define CPF_IDX_CTRL      8'h06

// Option register fields
`define CPF_OPT_STRIP     7
`define CPF_OPT_LIT_NEXT  6
`define CPF_OPT_MOE       5
`define CPF_OPT_MASK      8'he3

// Status register fields
`define CPF_ST_RX_ON      7
`define CPF_ST_RXFOFF     6
`define CPF_ST_RXFON      5
`define CPF_ST_TX_ON      3
`define CPF_ST_TXFOFF     2
`define CPF_ST_TXFON      1
`define CPF_ST_PAR_MASK   8'h88

// Command codes written to the command register
`define CPF_CMD_SEND_ONE  8'h21
`define CPF_CMD_SEND_TWO  8'h22

// Control register fields
`define CPF_CTL_RX_ON     0
`define CPF_CTL_TX_ON     1
`define CPF_CTL_PAR       2

// Characters and reset values
`define CPF_CHAR_CR       8'h0d
`define CPF_CHAR_NL       8'h0a
`define CPF_RST_BYTE      8'h00

`endif

//--- logic/cpf_pkg.sv
/*
 * Types for the character processing and flow status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package cpf_pkg;
    // Receive processing state
    typedef enum logic [0:0] {CPF_RX_NORMAL, CPF_RX_AFTER_LIT} cpf_rx_t;
    // Transmit translation state
    typedef enum logic [0:0] {CPF_TX_PASS, CPF_TX_SEND_NL} cpf_tx_t;
endpackage
`default_nettype wire

//--- logic/cpf_top.sv
/*
 * One channel of character processing and flow status with an APB
 * register slave: receive strip / literal-next / special matching,
 * transmit CR/NL translation, status and good-character count.
 * Assumes the receive FIFO reports its good-character count and that
 * the transmit path accepts one character per cycle when ready.
 */
// Operation
// - Strip received bit seven when option set
// - Error-free character after literal-next never special
// - Match errored characters only when enabled
// - Transmit translation per two option bits
// - Status shows receiver enabled
// - Status shows transmitter enabled
// - Receiver flow-off: send-two sets, send-one or enable change clears
// - Receiver flow-on: send-one sets, data clears
// - Transmitter flow-off set by XOFF received
// - Transmitter flow-on cleared when sending restarts
// - Serial count four bits, upper zero
// - Parallel count five bits, upper zero
// - Channel zero alone has parallel layout
// - All eight pattern bits compared
// - Special one is XON, two XOFF
// - Status read-only; parallel shows enables only
// - Literal-next and next stored unprocessed
// - Errored follower after literal-next handled normally
`include "cpf_consts.svh"
`default_nettype none
module cpf_top #(
    parameter int CHANNEL   = 0,
    parameter int SER_DEPTH = 12,
    parameter int PAR_DEPTH = 30
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Receive stream from line
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_char,
    input  wire logic        i_rx_error,
    input  wire logic        i_rx_break,
    output logic             o_rx_valid,
    output logic      [7:0]  o_rx_char,
    output logic             o_rx_error,
    output logic      [3:0]  o_rx_special,
    // Receive FIFO good count
    input  wire logic [4:0]  i_fifo_good_count,
    // Transmit stream
    input  wire logic        i_tx_valid,
    input  wire logic [7:0]  i_tx_char,
    output logic             o_tx_ready,
    output logic             o_tx_valid,
    output logic      [7:0]  o_tx_char,
    input  wire logic        i_line_ready
);

    initial
    begin
        if (CHANNEL < 0 || CHANNEL > 3 || SER_DEPTH != 12 ||
            PAR_DEPTH != 30)
            $error("cpf_top: unsupported parameters");
    end

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    logic [7:0]        sch_reg [4];
    logic [7:0]        opt_reg;
    logic [7:0]        literal_next_char_reg;
    logic [2:0]        ctl_reg;
    logic              rx_foff_reg;
    logic              rx_fon_reg;
    logic              tx_foff_reg;
    logic              tx_fon_reg;
    cpf_pkg::cpf_rx_t  rx_state_reg;
    cpf_pkg::cpf_tx_t  tx_state_reg;

    logic [9:0]        idx;
    logic              wr_en;
    logic              rd_en;
    logic              par_mode;
    logic              chan_toggle;
    logic              cmd_one;
    logic              cmd_two;

    assign idx      = i_paddr[11:2];
    assign wr_en    = i_psel && i_penable && i_pwrite && !o_pready;
    assign rd_en    = i_psel && i_penable && !i_pwrite && !o_pready;
    assign par_mode = (CHANNEL == 0) && ctl_reg[`CPF_CTL_PAR];
    assign cmd_one  = wr_en && idx == 10'(`CPF_IDX_CMD) &&
                      i_pwdata[7:0] == `CPF_CMD_SEND_ONE;
    assign cmd_two  = wr_en && idx == 10'(`CPF_IDX_CMD) &&
                      i_pwdata[7:0] == `CPF_CMD_SEND_TWO;
    // Any change of an enable bit counts as enable or disable
    assign chan_toggle = wr_en && idx == 10'(`CPF_IDX_CTRL) &&
                         i_pwdata[1:0] != ctl_reg[1:0];

    // Writable registers; unused option bits are masked out
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            for (int k = 0; k < 4; k++)
                sch_reg[k] <= `CPF_RST_BYTE;
            opt_reg   <= `CPF_RST_BYTE;
            literal_next_char_reg <= `CPF_RST_BYTE;
            ctl_reg   <= 3'h0;
        end
        else if (wr_en)
        begin
            unique case (idx)
                10'(`CPF_IDX_SCH1): sch_reg[0] <= i_pwdata[7:0];
                10'(`CPF_IDX_SCH2): sch_reg[1] <= i_pwdata[7:0];
                10'(`CPF_IDX_SCH3): sch_reg[2] <= i_pwdata[7:0];
                10'(`CPF_IDX_SCH4): sch_reg[3] <= i_pwdata[7:0];
                10'(`CPF_IDX_OPT5):
                    opt_reg <= i_pwdata[7:0] & `CPF_OPT_MASK;
                10'(`CPF_IDX_LIT_NEXT):
                    literal_next_char_reg <= i_pwdata[7:0];
                10'(`CPF_IDX_CTRL):
                    ctl_reg <= i_pwdata[2:0];
                default: ;
            endcase
        end
    end

    //----------------------------------------------------------------
    // Receive processing
    //----------------------------------------------------------------
    logic [7:0] rx_c;
    logic [3:0] hit;
    logic       rx_ok;
    logic       is_literal_next;
    logic       may_match;
    logic       rx_xon;
    logic       rx_xoff;

    // Strip bit seven before matching and delivery
    assign rx_c = opt_reg[`CPF_OPT_STRIP] ?
                  {1'b0, i_rx_char[6:0]} : i_rx_char;
    assign rx_ok = i_rx_valid && ctl_reg[`CPF_CTL_RX_ON];
    // Errored characters match only with the option set; an errored
    // follower of the literal-next character is not escaped
    assign may_match = rx_ok && !i_rx_break &&
                       (!i_rx_error || opt_reg[`CPF_OPT_MOE]) &&
                       (rx_state_reg == cpf_pkg::CPF_RX_NORMAL ||
                        i_rx_error);
    assign is_literal_next = may_match && !i_rx_error &&
                             opt_reg[`CPF_OPT_LIT_NEXT] &&
                             rx_c == literal_next_char_reg;

    // Full eight-bit compare per special character
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_match
            assign hit[g] = may_match && !is_literal_next &&
                            rx_c == sch_reg[g];
        end
    endgenerate

    assign rx_xon  = hit[0];
    assign rx_xoff = hit[1];

    // Literal-next tracker; error or break after it is not escaped
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            rx_state_reg <= cpf_pkg::CPF_RX_NORMAL;
        else if (rx_ok)
        begin
            unique case (rx_state_reg)
                cpf_pkg::CPF_RX_NORMAL:
                    if (is_literal_next)
                        rx_state_reg <= cpf_pkg::CPF_RX_AFTER_LIT;
                cpf_pkg::CPF_RX_AFTER_LIT:
                    rx_state_reg <= cpf_pkg::CPF_RX_NORMAL;
            endcase
        end
    end

    // Delivered receive stream with match flags
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_rx_valid   <= 1'b0;
            o_rx_char    <= `CPF_RST_BYTE;
            o_rx_error   <= 1'b0;
            o_rx_special <= 4'h0;
        end
        else
        begin
            o_rx_valid   <= rx_ok;
            o_rx_char    <= rx_c;
            o_rx_error   <= i_rx_error || i_rx_break;
            o_rx_special <= hit;
        end
    end

    //----------------------------------------------------------------
    // Transmit translation
    //----------------------------------------------------------------
    logic [1:0] xl;
    logic       tx_go;
    logic       tx_take;

    assign xl      = opt_reg[1:0];
    assign tx_go   = ctl_reg[`CPF_CTL_TX_ON] && !tx_foff_reg &&
                     (!o_tx_valid || i_line_ready);
    assign tx_take = tx_go && i_tx_valid &&
                     tx_state_reg == cpf_pkg::CPF_TX_PASS;

    // Translate CR and NL; mode three expands NL into CR then NL
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_tx_valid   <= 1'b0;
            o_tx_char    <= `CPF_RST_BYTE;
            o_tx_ready   <= 1'b0;
            tx_state_reg <= cpf_pkg::CPF_TX_PASS;
        end
        else
        begin
            o_tx_ready <= tx_go && tx_state_reg == cpf_pkg::CPF_TX_PASS;
            if (tx_go)
            begin
                o_tx_valid <= 1'b0;
                unique case (tx_state_reg)
                    cpf_pkg::CPF_TX_SEND_NL:
                    begin
                        o_tx_valid   <= 1'b1;
                        o_tx_char    <= `CPF_CHAR_NL;
                        tx_state_reg <= cpf_pkg::CPF_TX_PASS;
                    end
                    cpf_pkg::CPF_TX_PASS:
                        if (tx_take && o_tx_ready)
                        begin
                            o_tx_valid <= 1'b1;
                            o_tx_char  <= i_tx_char;
                            if (i_tx_char == `CPF_CHAR_CR && xl[0])
                                o_tx_char <= `CPF_CHAR_NL;
                            else if (i_tx_char == `CPF_CHAR_NL && xl[1])
                            begin
                                o_tx_char <= `CPF_CHAR_CR;
                                if (xl[0])
                                    tx_state_reg <= cpf_pkg::CPF_TX_SEND_NL;
                            end
                        end
                endcase
            end
            // Line takes the held character even while stopped
            else if (o_tx_valid && i_line_ready)
                o_tx_valid <= 1'b0;
        end
    end

    //----------------------------------------------------------------
    // Flow status flags
    //----------------------------------------------------------------
    logic tx_restart;

    assign tx_restart = o_tx_valid && i_line_ready;

    // Receiver side: set by commands; send-one or enables clear flow-off, data or enables flow-on
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            rx_foff_reg <= 1'b0;
            rx_fon_reg  <= 1'b0;
        end
        else
        begin
            if (cmd_two)
                rx_foff_reg <= 1'b1;
            else if (cmd_one || chan_toggle)
                rx_foff_reg <= 1'b0;
            if (cmd_one)
                rx_fon_reg <= 1'b1;
            else if (chan_toggle || (rx_ok && !rx_xon && !rx_xoff))
                rx_fon_reg <= 1'b0;
        end
    end

    // Transmitter side: set by received XON/XOFF, set wins
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            tx_foff_reg <= 1'b0;
            tx_fon_reg  <= 1'b0;
        end
        else
        begin
            if (rx_xoff)
                tx_foff_reg <= 1'b1;
            else if (rx_xon || chan_toggle)
                tx_foff_reg <= 1'b0;
            if (rx_xon)
                tx_fon_reg <= 1'b1;
            else if (tx_restart || chan_toggle)
                tx_fon_reg <= 1'b0;
        end
    end

    //----------------------------------------------------------------
    // APB read and answer
    //----------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] count;
    logic       mapped;

    always_comb
    begin
        status = 8'h00;
        status[`CPF_ST_RX_ON]  = ctl_reg[`CPF_CTL_RX_ON];
        status[`CPF_ST_TX_ON]  = ctl_reg[`CPF_CTL_TX_ON];
        status[`CPF_ST_RXFOFF] = rx_foff_reg;
        status[`CPF_ST_RXFON]  = rx_fon_reg;
        status[`CPF_ST_TXFOFF] = tx_foff_reg;
        status[`CPF_ST_TXFON]  = tx_fon_reg;
        if (par_mode)
            status = status & `CPF_ST_PAR_MASK;
        if (par_mode)
            count = {3'h0, i_fifo_good_count};
        else
            count = {4'h0, i_fifo_good_count[3:0]};
    end

    assign mapped = idx == 10'(`CPF_IDX_STATUS) ||
                    idx == 10'(`CPF_IDX_COUNT) ||
                    idx == 10'(`CPF_IDX_SCH1) ||
                    idx == 10'(`CPF_IDX_SCH2) ||
                    idx == 10'(`CPF_IDX_SCH3) ||
                    idx == 10'(`CPF_IDX_SCH4) ||
                    idx == 10'(`CPF_IDX_OPT5) ||
                    idx == 10'(`CPF_IDX_LIT_NEXT) ||
                    idx == 10'(`CPF_IDX_CMD) ||
                    idx == 10'(`CPF_IDX_CTRL);

    // One wait state: answer one cycle into the access phase
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end
        else
        begin
            o_pready  <= wr_en || rd_en;
            o_pslverr <= (wr_en || rd_en) && !mapped;
            o_prdata  <= 32'h0;
            if (rd_en)
            begin
                unique case (idx)
                    10'(`CPF_IDX_STATUS): o_prdata <= {24'h0, status};
                    10'(`CPF_IDX_COUNT):  o_prdata <= {24'h0, count};
                    10'(`CPF_IDX_SCH1):   o_prdata <= {24'h0, sch_reg[0]};
                    10'(`CPF_IDX_SCH2):   o_prdata <= {24'h0, sch_reg[1]};
                    10'(`CPF_IDX_SCH3):   o_prdata <= {24'h0, sch_reg[2]};
                    10'(`CPF_IDX_SCH4):   o_prdata <= {24'h0, sch_reg[3]};
                    10'(`CPF_IDX_OPT5):   o_prdata <= {24'h0, opt_reg};
                    10'(`CPF_IDX_LIT_NEXT):
                        o_prdata <= {24'h0, literal_next_char_reg};
                    10'(`CPF_IDX_CTRL):   o_prdata <= {29'h0, ctl_reg};
                    default: ;
                endcase
            end
        end
    end

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    sequence s_xoff_rx;
        rx_xoff;
    endsequence
    sequence s_foff_high;
        tx_foff_reg;
    endsequence

    AST_STRIP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        rx_ok && opt_reg[7] |=> !o_rx_char[7])
        else $error("bit seven not stripped");
    AST_LITERAL_NEXT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        rx_state_reg == cpf_pkg::CPF_RX_AFTER_LIT && rx_ok &&
        !i_rx_error |-> hit == 4'h0)
        else $error("escaped character matched");
    AST_MOE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_rx_error && !opt_reg[5] |-> hit == 4'h0)
        else $error("errored character matched");
    AST_XOFF: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_xoff_rx |=> s_foff_high)
        else $error("xoff not recorded");
    AST_TXSTOP: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        tx_foff_reg |=> !$rose(o_tx_valid))
        else $error("sent while flowed off");
    AST_RXFOFF: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        cmd_two |=> status[6] || par_mode)
        else $error("rx flow off not set");
    AST_RXFON: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        cmd_one |=> rx_fon_reg && !rx_foff_reg)
        else $error("rx flow on wrong");
    AST_EXPAND: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        tx_take && o_tx_ready && i_tx_char == 8'h0a && xl == 2'h3
        |=> o_tx_char == 8'h0d ##[1:300] o_tx_char == 8'h0a)
        else $error("nl not expanded");
    AST_COUNT: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        rd_en && idx == 10'(`CPF_IDX_COUNT) && !par_mode
        |=> o_prdata[7:4] == 4'h0)
        else $error("count upper bits set");

endmodule
`default_nettype wire

//--- testbench/cpf_remote.sv
/*
 * Remote serial device model: sends characters into the receive
 * stream and takes translated characters off the transmit line.
 * Assumes one system clock and a bench that calls send().
 */
`default_nettype none
module cpf_remote (
    // Clock
    input  wire logic       i_clk,
    // Receive stream toward the block
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_char,
    output logic            o_rx_error,
    output logic            o_rx_break,
    // Transmit line
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_char,
    output logic            o_line_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txq [$];

    // Idle levels at time zero
    initial
    begin
        o_rx_valid   = 1'b0;
        o_rx_char    = 8'h5a;
        o_rx_error   = 1'b0;
        o_rx_break   = 1'b0;
        o_line_ready = 1'b0;
    end

    // Line accepts at random, stalling about one cycle in four
    always @(posedge i_clk)
    begin
        o_line_ready <= ($urandom % 4) != 0;
        if (i_tx_valid && o_line_ready)
            txq.push_back(i_tx_char);
    end

    // One character per pulse; data inverted once the pulse ends
    task automatic send(input logic [7:0] c, input logic err);
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx_char  <= c;
        o_rx_error <= err;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_char  <= ~c;
        o_rx_error <= ~err;
    endtask
endmodule
`default_nettype wire

//--- testbench/cpf_top_bench.sv
/*
 * Self-checking bench: registers over APB, receive processing, flow
 * flags, good count and transmit translation.
 * Assumes cpf_remote stands on the line side.
 */
`include "cpf_consts.svh"
`default_nettype none
module cpf_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, ov, oe, rxv, rxe, rxb, lrdy;
    logic        txv = 1'b0, txr, otv;
    logic [7:0]  txc = 8'h00, oc, rxc, otc, c, v;
    logic [3:0]  osp;
    logic [4:0]  fcnt = 5'h00;
    logic [7:0]  sch [4];
    logic [7:0]  exq [$];
    int          num_errors = 0, checked = 0, cycles = 0, n;

    always #2 clk = ~clk;

    cpf_top uut (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_rx_valid(rxv), .i_rx_char(rxc),
        .i_rx_error(rxe), .i_rx_break(rxb), .o_rx_valid(ov),
        .o_rx_char(oc), .o_rx_error(oe), .o_rx_special(osp),
        .i_fifo_good_count(fcnt), .i_tx_valid(txv), .i_tx_char(txc),
        .o_tx_ready(txr), .o_tx_valid(otv), .o_tx_char(otc),
        .i_line_ready(lrdy)
    );
    cpf_remote rem (
        .i_clk(clk), .o_rx_valid(rxv), .o_rx_char(rxc),
        .o_rx_error(rxe), .o_rx_break(rxb), .i_tx_valid(otv),
        .i_tx_char(otc), .o_line_ready(lrdy)
    );

    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    // Verdict and end of run
    task automatic stop_test;
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer, held until pready at an edge
    task automatic apb(input logic w, input logic [7:0] ix,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, ix, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        apb(1'b1, ix, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 32'h0);
        chk({rerr, rdat[30:0]}, {1'b0, 23'h0, e});
    endtask
    // Send one character and compare what is delivered
    task automatic rx(input logic [7:0] ch, input logic er,
                      input logic [7:0] ec, input logic [3:0] es);
        rem.send(ch, er);
        #1;
        chk({18'h0, ov, oe, osp, oc}, {18'h0, 1'b1, er, es, ec});
    endtask
    // Hand one character to the transmit side
    task automatic tx(input logic [7:0] ch);
        @(posedge clk);
        txv <= 1'b1;
        txc <= ch;
        do
            @(posedge clk);
        while (txr !== 1'b1);
        txv <= 1'b0;
    endtask
    // Expected line characters for one host character
    task automatic xl(input logic [1:0] m, input logic [7:0] ch);
        if (ch == `CPF_CHAR_CR && m[0])
            exq.push_back(`CPF_CHAR_NL);
        else if (ch == `CPF_CHAR_NL && m == 2'b10)
            exq.push_back(`CPF_CHAR_CR);
        else if (ch == `CPF_CHAR_NL && m == 2'b11)
        begin
            exq.push_back(`CPF_CHAR_CR);
            exq.push_back(`CPF_CHAR_NL);
        end
        else
            exq.push_back(ch);
    endtask
    // Wait, bounded, until the line has taken all expected characters
    task automatic drain;
        n = 0;
        while (rem.txq.size() < exq.size() && n < 300)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    // Cut a hung run short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial
    begin
        void'($urandom(24975));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values, refusal, option mask, read-only status
        for (int i = 0; i < 4; i++)
            rd(8'(`CPF_IDX_SCH1 + i), 8'h00);
        apb(1'b0, 8'h30, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h8000_0000);
        wr(`CPF_IDX_OPT5, 8'hff);
        rd(`CPF_IDX_OPT5, `CPF_OPT_MASK);
        for (int k = 0; k < 4; k++)
        begin
            v = 8'(k);
            wr(`CPF_IDX_CTRL, v);
            wr(`CPF_IDX_STATUS, 8'hff);
            rd(`CPF_IDX_STATUS, {v[0], 3'h0, v[1], 3'h0});
        end
        // Special patterns, full eight bits, software keeps them 8-bit
        sch[0] = 8'h11;
        sch[1] = 8'h13;
        sch[2] = 8'h40 | 8'($urandom % 32);
        sch[3] = 8'he0 | 8'($urandom % 32);
        for (int i = 0; i < 4; i++)
            wr(8'(`CPF_IDX_SCH1 + i), sch[i]);
        for (int i = 0; i < 4; i++)
            rd(8'(`CPF_IDX_SCH1 + i), sch[i]);
        wr(`CPF_IDX_LIT_NEXT, 8'h16);
        // High bit strip on and off with random characters
        for (int i = 0; i < 16; i++)
        begin
            c = (8'($urandom) & 8'h8f) | 8'h20;
            wr(`CPF_IDX_OPT5, {i[0], 7'h00});
            rx(c, 1'b0, i[0] ? (c & 8'h7f) : c, 4'h0);
        end
        // Matching on all bits, errored characters, literal-next
        wr(`CPF_IDX_OPT5, 8'h00);
        rx(sch[2], 1'b0, sch[2], 4'b0100);
        rx(sch[3], 1'b0, sch[3], 4'b1000);
        rx(sch[3] & 8'h7f, 1'b0, sch[3] & 8'h7f, 4'h0);
        rx(sch[2], 1'b1, sch[2], 4'h0);
        wr(`CPF_IDX_OPT5, 8'h20);
        rx(sch[2], 1'b1, sch[2], 4'b0100);
        wr(`CPF_IDX_OPT5, 8'h60);
        rx(8'h16, 1'b0, 8'h16, 4'h0);
        rx(sch[2], 1'b0, sch[2], 4'h0);
        rx(sch[2], 1'b0, sch[2], 4'b0100);
        rx(8'h16, 1'b0, 8'h16, 4'h0);
        rx(sch[2], 1'b1, sch[2], 4'b0100);
        // Receiver and transmitter flow flags
        wr(`CPF_IDX_OPT5, 8'h00);
        wr(`CPF_IDX_CMD, `CPF_CMD_SEND_TWO);
        rd(`CPF_IDX_STATUS, 8'hc8);
        wr(`CPF_IDX_CMD, `CPF_CMD_SEND_ONE);
        rd(`CPF_IDX_STATUS, 8'ha8);
        rx(8'h30, 1'b0, 8'h30, 4'h0);
        rd(`CPF_IDX_STATUS, 8'h88);
        wr(`CPF_IDX_CMD, `CPF_CMD_SEND_TWO);
        wr(`CPF_IDX_CTRL, 8'h01);
        rd(`CPF_IDX_STATUS, 8'h80);
        wr(`CPF_IDX_CTRL, 8'h03);
        rx(sch[1], 1'b0, sch[1], 4'b0010);
        rd(`CPF_IDX_STATUS, 8'h8c);
        chk({31'h0, txr}, 32'h0);
        rx(sch[0], 1'b0, sch[0], 4'b0001);
        rd(`CPF_IDX_STATUS, 8'h8a);
        xl(2'b00, 8'h41);
        tx(8'h41);
        drain();
        rd(`CPF_IDX_STATUS, 8'h88);
        // Transmit translation in every mode
        for (int m = 0; m < 4; m++)
        begin
            wr(`CPF_IDX_OPT5, 8'(m));
            for (int j = 0; j < 3; j++)
            begin
                c = (j == 0) ? `CPF_CHAR_CR : (j == 1) ? `CPF_CHAR_NL
                    : 8'($urandom);
                xl(2'(m), c);
                tx(c);
            end
            drain();
        end
        chk(32'(rem.txq.size()), 32'(exq.size()));
        for (int i = 0; i < exq.size() && i < rem.txq.size(); i++)
            chk({24'h0, rem.txq[i]}, {24'h0, exq[i]});
        // Good count, serial then parallel layout
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h0c : 8'(1 + $urandom % 12);
            fcnt <= v[4:0];
            rd(`CPF_IDX_COUNT, {4'h0, v[3:0]});
        end
        wr(`CPF_IDX_CMD, `CPF_CMD_SEND_TWO);
        wr(`CPF_IDX_CTRL, 8'h07);
        rd(`CPF_IDX_STATUS, 8'h88);
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h1e : 8'(1 + $urandom % 30);
            fcnt <= v[4:0];
            rd(`CPF_IDX_COUNT, {3'h0, v[4:0]});
        end
        stop_test();
    end
endmodule
`default_nettype wire
